// [hw/tmc_cmd_engine.sv]
// mapping command engine: collection, device table and identity event bind
//
// Strobed register access and the register addresses are this design's own decisions.
module tmc_cmd_engine (
   // clock and reset
   input  wire  logic                  mclk_in,
   input  wire  logic                  rstn_in,
   // command packets from the queue
   input  wire  logic                  cmd_valid_in,
   input  wire  tmc_pkg::tmc_packet_type cmd_packet_in,
   output logic                        cmd_ready_out,
   output logic                        rdptr_adv_out,
   // translation table write port
   output logic                        tt_wr_valid_out,
   output logic [51:0]                 tt_wr_addr_out,
   output tmc_pkg::tmc_ite_type        tt_wr_data_out,
   output logic [3:0]                  tt_wr_attr_out,
   input  wire  logic                  tt_wr_ready_in,
   // cache invalidation and error reporting
   output logic                        cache_inval_out,
   output logic [3:0]                  cache_inval_dev_out,
   output logic                        sys_error_out,
   output tmc_pkg::tmc_err_type        sys_error_cause_out,
   // translation request lookup
   input  wire  logic                  lk_valid_in,
   input  wire  logic [31:0]           lk_requester_in,
   input  wire  logic [31:0]           lk_event_in,
   input  wire  logic [15:0]           lk_collection_in,
   output logic                        lk_done_out,
   output logic                        lk_accept_out,
   output logic                        lk_col_valid_out,
   output logic [34:0]                 lk_target_out,
   // register port
   input  wire  logic [3:0]            reg_addr_in,
   input  wire  logic [31:0]           reg_wdata_in,
   input  wire  logic                  reg_wr_in,
   input  wire  logic                  reg_rd_in,
   output logic [31:0]                 reg_rdata_out
);

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WRITE} tmc_state_type;

   tmc_state_type           state_ff;
   tmc_pkg::tmc_packet_type pkt_ff;
   tmc_pkg::tmc_dte_type    dte_ff [tmc_pkg::DEV_COUNT];
   tmc_pkg::tmc_cte_type    cte_ff [tmc_pkg::COL_COUNT];
   logic [31:0]             ctrl_ff;
   logic [31:0]             rdptr_ff;
   logic [31:0]             errcnt_ff;
   logic                    err_flag_ff;
   tmc_pkg::tmc_err_type    err_cause_ff;
   logic [31:0]             rdata_ff;

   tmc_pkg::tmc_err_type    nxt_err;
   tmc_pkg::tmc_dte_type    cur_dte;
   logic [7:0]              opcode;
   logic [31:0]             requester_number;
   logic [31:0]             event_number;
   logic [15:0]             collection_number;
   logic                    bind_valid;
   logic [4:0]              size_field;
   logic [4:0]              event_width_limit;
   logic [34:0]             target_unit_field;
   logic                    exec_done;
   logic                    advance;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // event fits when no bit at or above size+1 is set
   function automatic logic id_out_of_range(input logic [31:0] evt,
                                            input logic [4:0]  size);
      logic [5:0] bits;
      bits = {1'b0, size} + 6'h01;
      return (bits >= 6'h20) ? 1'b0 : ((evt >> bits) != 32'h0);
   endfunction

   function automatic logic dev_oor(input logic [31:0] dev);
      return dev >= tmc_pkg::DEV_LIMIT;
   endfunction

   function automatic logic col_oor(input logic [15:0] col);
      return col >= tmc_pkg::COL_LIMIT;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // packet fields

   assign opcode            = pkt_ff.dw0[7:0];
   assign requester_number  = pkt_ff.dw0[63:32];
   assign event_number      = pkt_ff.dw1[31:0];
   assign size_field        = pkt_ff.dw1[4:0];
   assign collection_number = pkt_ff.dw2[15:0];
   assign bind_valid        = pkt_ff.dw2[tmc_pkg::VALID_BIT];
   assign event_width_limit = ctrl_ff[tmc_pkg::CTL_LIM_LSB +: 5];
   assign cur_dte           = dte_ff[requester_number[3:0]];

   // physical format drops bits above 47; unmapped target stored as zero
   always_comb begin
      target_unit_field = pkt_ff.dw2[tmc_pkg::TGT_MSB:tmc_pkg::TGT_LSB];
      if (ctrl_ff[tmc_pkg::CTL_PHYS]) begin
         target_unit_field[34:32] = 3'h0;
      end
      if (!bind_valid) begin
         target_unit_field = 35'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command checks

   always_comb begin
      nxt_err = tmc_pkg::ERR_NONE;
      unique case (opcode)
         tmc_pkg::OP_COL_BIND: begin
            if (col_oor(collection_number)) begin
               nxt_err = tmc_pkg::ERR_COL_OOR;
            end
         end
         tmc_pkg::OP_DEV_BIND: begin
            if (dev_oor(requester_number)) begin
               nxt_err = tmc_pkg::ERR_DEV_OOR;
            end else if (bind_valid && size_field > event_width_limit) begin
               nxt_err = tmc_pkg::ERR_SIZE_OOR;
            end
         end
         tmc_pkg::OP_EVT_BIND: begin
            if (dev_oor(requester_number)) begin
               nxt_err = tmc_pkg::ERR_DEV_OOR;
            end else if (col_oor(collection_number)) begin
               nxt_err = tmc_pkg::ERR_COL_OOR;
            end else if (!cur_dte.valid) begin
               nxt_err = tmc_pkg::ERR_UNMAPPED_DEV;
            end else if (id_out_of_range(event_number, cur_dte.size)) begin
               nxt_err = tmc_pkg::ERR_ID_OOR;
            end else if (event_number < tmc_pkg::MIN_MSG_IRQ) begin
               nxt_err = tmc_pkg::ERR_NOT_MSG_IRQ;
            end
         end
         default: nxt_err = tmc_pkg::ERR_BAD_OP;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencing

   assign cmd_ready_out = (state_ff == ST_IDLE);
   assign exec_done     = (state_ff == ST_EXEC) &&
                          (nxt_err != tmc_pkg::ERR_NONE ||
                           opcode != tmc_pkg::OP_EVT_BIND);
   // failed commands are skipped so the queue cannot wedge
   assign advance       = exec_done ||
                          (state_ff == ST_WRITE && tt_wr_ready_in);

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         state_ff <= ST_IDLE;
      end else begin
         unique case (state_ff)
            ST_IDLE:  if (cmd_valid_in) state_ff <= ST_EXEC;
            ST_EXEC:  state_ff <= exec_done ? ST_IDLE : ST_WRITE;
            ST_WRITE: if (tt_wr_ready_in) state_ff <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         pkt_ff <= '0;
      end else if (cmd_ready_out && cmd_valid_in) begin
         pkt_ff <= cmd_packet_in;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         rdptr_ff      <= 32'h0;
         rdptr_adv_out <= 1'b0;
      end else begin
         rdptr_adv_out <= advance;
         if (advance) begin
            rdptr_ff <= rdptr_ff + tmc_pkg::CMD_BYTES;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // collection and device tables

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < tmc_pkg::COL_COUNT; i++) cte_ff[i] <= '0;
      end else if (state_ff == ST_EXEC && nxt_err == tmc_pkg::ERR_NONE &&
                   opcode == tmc_pkg::OP_COL_BIND) begin
         // valid 0 clears the entry so its interrupts are ignored
         cte_ff[collection_number[3:0]] <= {bind_valid, target_unit_field};
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < tmc_pkg::DEV_COUNT; i++) dte_ff[i] <= '0;
      end else if (state_ff == ST_EXEC && nxt_err == tmc_pkg::ERR_NONE &&
                   opcode == tmc_pkg::OP_DEV_BIND) begin
         // base low eight bits are implied zero: 256-byte aligned
         dte_ff[requester_number[3:0]] <=
            {bind_valid, pkt_ff.dw2[tmc_pkg::TTA_MSB:tmc_pkg::TTA_LSB],
             size_field};
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         cache_inval_out     <= 1'b0;
         cache_inval_dev_out <= 4'h0;
      end else begin
         cache_inval_out <= state_ff == ST_EXEC &&
                            nxt_err == tmc_pkg::ERR_NONE &&
                            opcode == tmc_pkg::OP_DEV_BIND &&
                            cur_dte.valid;
         if (state_ff == ST_EXEC) begin
            cache_inval_dev_out <= requester_number[3:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // translation entry write

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         tt_wr_valid_out <= 1'b0;
         tt_wr_addr_out  <= 52'h0;
         tt_wr_data_out  <= '0;
         tt_wr_attr_out  <= 4'h0;
      end else if (state_ff == ST_EXEC && !exec_done) begin
         tt_wr_valid_out <= 1'b1;
         tt_wr_addr_out  <= {cur_dte.base_hi, 8'h00} +
                            event_number[31:0] * tmc_pkg::ENTRY_BYTES;
         tt_wr_data_out  <= {1'b1, 1'b1, collection_number,
                             event_number};
         tt_wr_attr_out  <= ctrl_ff[tmc_pkg::CTL_ATTR_LSB +: 4];
      end else if (state_ff == ST_WRITE && tt_wr_ready_in) begin
         tt_wr_valid_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // error reporting

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         sys_error_out       <= 1'b0;
         sys_error_cause_out <= tmc_pkg::ERR_NONE;
         err_flag_ff         <= 1'b0;
         err_cause_ff        <= tmc_pkg::ERR_NONE;
         errcnt_ff           <= 32'h0;
      end else begin
         sys_error_out <= state_ff == ST_EXEC &&
                          nxt_err != tmc_pkg::ERR_NONE &&
                          ctrl_ff[tmc_pkg::CTL_SYSERR];
         if (state_ff == ST_EXEC && nxt_err != tmc_pkg::ERR_NONE) begin
            sys_error_cause_out <= nxt_err;
            err_cause_ff        <= nxt_err;
            err_flag_ff         <= 1'b1;
            errcnt_ff           <= errcnt_ff + 32'h1;
         end else if (reg_wr_in && reg_addr_in == tmc_pkg::REG_STATUS &&
                      reg_wdata_in[0]) begin
            // a new error in the clear cycle wins over the clear
            err_flag_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request lookup

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         lk_done_out      <= 1'b0;
         lk_accept_out    <= 1'b0;
         lk_col_valid_out <= 1'b0;
         lk_target_out    <= 35'h0;
      end else begin
         lk_done_out <= lk_valid_in;
         // unmapped devices and oversize events are discarded
         lk_accept_out <= lk_valid_in && !dev_oor(lk_requester_in) &&
            dte_ff[lk_requester_in[3:0]].valid &&
            !id_out_of_range(lk_event_in,
                             dte_ff[lk_requester_in[3:0]].size);
         lk_col_valid_out <= lk_valid_in && !col_oor(lk_collection_in) &&
                             cte_ff[lk_collection_in[3:0]].valid;
         lk_target_out <= cte_ff[lk_collection_in[3:0]].target;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register port

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         ctrl_ff <= tmc_pkg::CTRL_RESET;
      end else if (reg_wr_in && reg_addr_in == tmc_pkg::REG_CTRL) begin
         ctrl_ff <= reg_wdata_in & 32'h0000_f1f3;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         rdata_ff <= 32'h0;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            tmc_pkg::REG_CTRL:   rdata_ff <= ctrl_ff;
            tmc_pkg::REG_STATUS: rdata_ff <= {24'h0, state_ff != ST_IDLE,
                                              err_cause_ff, 3'h0,
                                              err_flag_ff};
            tmc_pkg::REG_RDPTR:  rdata_ff <= rdptr_ff;
            tmc_pkg::REG_ERRCNT: rdata_ff <= errcnt_ff;
            default:             rdata_ff <= 32'h0;
         endcase
      end else begin
         rdata_ff <= 32'h0;
      end
   end

   assign reg_rdata_out = rdata_ff;

endmodule

// [hw/tmc_pkg.sv]
// constants, field layouts and types of the mapping command engine
package tmc_pkg;

   // table sizes supported by this engine
   localparam int            DEV_COUNT     = 16;
   localparam int            COL_COUNT     = 16;
   localparam logic [31:0]   DEV_LIMIT     = 32'h0000_0010;
   localparam logic [15:0]   COL_LIMIT     = 16'h0010;
   localparam logic [31:0]   CMD_BYTES     = 32'h0000_0020;
   localparam logic [31:0]   MIN_MSG_IRQ   = 32'h0000_2000;
   localparam logic [51:0]   ENTRY_BYTES   = 52'h0_0000_0000_0008;

   // command codes in bits 7:0 of word 0
   localparam logic [7:0]    OP_COL_BIND   = 8'h01;
   localparam logic [7:0]    OP_DEV_BIND   = 8'h02;
   localparam logic [7:0]    OP_EVT_BIND   = 8'h03;

   // field positions
   localparam int            VALID_BIT     = 63;
   localparam int            TGT_LSB       = 16;
   localparam int            TGT_MSB       = 50;
   localparam int            PHYS_MSB      = 47;
   localparam int            TTA_LSB       = 8;
   localparam int            TTA_MSB       = 51;

   // register indices on the plain port
   localparam logic [3:0]    REG_CTRL      = 4'h0;
   localparam logic [3:0]    REG_STATUS    = 4'h1;
   localparam logic [3:0]    REG_RDPTR     = 4'h2;
   localparam logic [3:0]    REG_ERRCNT    = 4'h3;

   // control register fields and reset value
   localparam int            CTL_SYSERR    = 0;
   localparam int            CTL_PHYS      = 1;
   localparam int            CTL_LIM_LSB   = 4;
   localparam int            CTL_ATTR_LSB  = 12;
   localparam logic [31:0]   CTRL_RESET    = 32'h0000_00f3;

   typedef enum logic [2:0] {
      ERR_NONE, ERR_COL_OOR, ERR_DEV_OOR, ERR_SIZE_OOR,
      ERR_UNMAPPED_DEV, ERR_ID_OOR, ERR_NOT_MSG_IRQ, ERR_BAD_OP
   } tmc_err_type;

   typedef struct packed {
      logic [63:0] dw3;
      logic [63:0] dw2;
      logic [63:0] dw1;
      logic [63:0] dw0;
   } tmc_packet_type;

   typedef struct packed {
      logic        valid;
      logic [43:0] base_hi;
      logic [4:0]  size;
   } tmc_dte_type;

   typedef struct packed {
      logic        valid;
      logic [34:0] target;
   } tmc_cte_type;

   typedef struct packed {
      logic        valid;
      logic        physical;
      logic [15:0] collection_number;
      logic [31:0] physical_irq_number;
   } tmc_ite_type;

endpackage

// [testbench/tmc_cmd_engine_asserts.sv]
// checker of the mapping command engine ports
module tmc_cmd_engine_asserts (
   // clock, reset and command port
   input wire logic                    mclk_in,
   input wire logic                    rstn_in,
   input wire logic                    cmd_valid_in,
   input wire tmc_pkg::tmc_packet_type cmd_packet_in,
   input wire logic                    cmd_ready_out,
   input wire logic                    rdptr_adv_out,
   // table write and errors
   input wire logic                    tt_wr_valid_out,
   input wire logic [51:0]             tt_wr_addr_out,
   input wire tmc_pkg::tmc_ite_type    tt_wr_data_out,
   input wire logic [3:0]              tt_wr_attr_out,
   input wire logic                    tt_wr_ready_in,
   input wire logic                    sys_error_out,
   input wire tmc_pkg::tmc_err_type    sys_error_cause_out,
   // lookup and register port
   input wire logic                    lk_valid_in,
   input wire logic [31:0]             lk_requester_in,
   input wire logic [15:0]             lk_collection_in,
   input wire logic                    lk_done_out,
   input wire logic                    lk_accept_out,
   input wire logic                    lk_col_valid_out,
   input wire logic [3:0]              reg_addr_in,
   input wire logic [31:0]             reg_wdata_in,
   input wire logic                    reg_wr_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] attr_ff;
   logic       syserr_ff;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);

   // shadow of the control fields the outputs depend on
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         attr_ff   <= tmc_pkg::CTRL_RESET[15:12];
         syserr_ff <= tmc_pkg::CTRL_RESET[0];
      end else if (reg_wr_in && reg_addr_in == tmc_pkg::REG_CTRL) begin
         attr_ff   <= reg_wdata_in[15:12];
         syserr_ff <= reg_wdata_in[0];
      end
   end

   sequence s_take;
      cmd_valid_in && cmd_ready_out;
   endsequence
   sequence s_accept;
      tt_wr_valid_out && tt_wr_ready_in;
   endsequence

   chk_plain_advance: assert property (s_take ##0
      (cmd_packet_in.dw0[7:0] != tmc_pkg::OP_EVT_BIND) |-> ##2 rdptr_adv_out)
      else $error("pointer not advanced two cycles after command");
   chk_busy_refuse: assert property (s_take |=> !cmd_ready_out)
      else $error("engine ready while executing");
   chk_write_hold: assert property (
      tt_wr_valid_out && !tt_wr_ready_in |=> tt_wr_valid_out
      && $stable(tt_wr_addr_out) && $stable(tt_wr_data_out))
      else $error("entry write dropped or changed before acceptance");
   chk_write_then_adv: assert property (
      s_accept |=> rdptr_adv_out && !tt_wr_valid_out)
      else $error("no pointer advance after entry write");
   chk_adv_single: assert property (rdptr_adv_out |=> !rdptr_adv_out)
      else $error("pointer advance longer than one cycle");
   chk_entry_identity: assert property (tt_wr_valid_out |->
      tt_wr_data_out.valid && tt_wr_data_out.physical
      && tt_wr_data_out.physical_irq_number >= tmc_pkg::MIN_MSG_IRQ
      && tt_wr_addr_out[2:0] == 3'h0)
      else $error("written entry not a valid physical mapping");
   chk_attr_follow: assert property (
      tt_wr_valid_out |-> tt_wr_attr_out == attr_ff)
      else $error("table write attributes differ from control");
   chk_err_gated: assert property (sys_error_out |-> syserr_ff
      && sys_error_cause_out != tmc_pkg::ERR_NONE)
      else $error("system error without support or cause");
   chk_lookup_done: assert property (
      1'b1 |=> lk_done_out == $past(lk_valid_in))
      else $error("lookup done not one cycle after request");
   chk_lk_col_range: assert property (lk_done_out &&
      $past(lk_collection_in) >= tmc_pkg::COL_LIMIT |-> !lk_col_valid_out)
      else $error("out of range collection reported mapped");
   chk_lk_dev_range: assert property (lk_done_out &&
      $past(lk_requester_in) >= tmc_pkg::DEV_LIMIT |-> !lk_accept_out)
      else $error("out of range device accepted");
endmodule

bind tmc_cmd_engine tmc_cmd_engine_asserts chk_u (
   .mclk_in, .rstn_in, .cmd_valid_in, .cmd_packet_in, .cmd_ready_out,
   .rdptr_adv_out, .tt_wr_valid_out, .tt_wr_addr_out, .tt_wr_data_out,
   .tt_wr_attr_out, .tt_wr_ready_in, .sys_error_out, .sys_error_cause_out,
   .lk_valid_in, .lk_requester_in, .lk_collection_in, .lk_done_out,
   .lk_accept_out, .lk_col_valid_out, .reg_addr_in, .reg_wdata_in,
   .reg_wr_in
);

// [testbench/tmc_table_model.sv]
// far side model: translation table memory with a slow write port
module tmc_table_model #(
   parameter int STALL = 3
) (
   // clock and reset
   input  wire logic                 mclk_in,
   input  wire logic                 rstn_in,
   // entry write port
   input  wire logic                 wr_valid_in,
   input  wire logic [51:0]          addr_in,
   input  wire tmc_pkg::tmc_ite_type data_in,
   input  wire logic [3:0]           attr_in,
   output logic                      ready_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0]           wait_ff;
   logic [51:0]          last_addr_ff;
   tmc_pkg::tmc_ite_type last_data_ff;
   logic [3:0]           last_attr_ff;
   logic [7:0]           count_ff;

   // every write is stalled so the engine has to hold it
   assign ready_out = wr_valid_in && (wait_ff == 4'(STALL));
   always_ff @(posedge mclk_in) begin
      if (!rstn_in || !wr_valid_in || ready_out) begin
         wait_ff <= 4'h0;
      end else begin
         wait_ff <= wait_ff + 4'h1;
      end
   end
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         count_ff <= 8'h0;
      end else if (wr_valid_in && ready_out) begin
         last_addr_ff <= addr_in;
         last_data_ff <= data_in;
         last_attr_ff <= attr_in;
         count_ff     <= count_ff + 8'h1;
      end
   end
endmodule

// [testbench/tmc_tb.sv]
// self-checking bench of the mapping command engine
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [43:0] BASE = 44'h123_4567_89ab;
   logic mclk_in, rstn_in, cmd_valid_in, lk_valid_in, reg_wr_in, reg_rd_in;
   logic cmd_ready_out, rdptr_adv_out, tt_wr_valid_out, tt_wr_ready_in;
   logic cache_inval_out, sys_error_out, lk_done_out, lk_accept_out;
   logic lk_col_valid_out, got_err, got_inv;
   tmc_pkg::tmc_packet_type cmd_packet_in;
   tmc_pkg::tmc_ite_type    tt_wr_data_out;
   tmc_pkg::tmc_err_type    sys_error_cause_out;
   logic [51:0]             tt_wr_addr_out;
   logic [34:0]             lk_target_out;
   logic [31:0]             lk_requester_in, lk_event_in;
   logic [31:0]             reg_wdata_in, reg_rdata_out;
   logic [15:0]             lk_collection_in;
   logic [3:0]              reg_addr_in, tt_wr_attr_out;
   logic [3:0]              cache_inval_dev_out, inv_dev;
   int                      failures, checks, ncmd, cyc, i;
   logic [31:0] e_dev [6] = '{32'h10, 32'h2, 32'h5, 32'h2, 32'h2, 32'h2};
   logic [31:0] e_ev [6] = '{32'h2000, 32'h2000, 32'h2000, 32'h1_0000,
                             32'h1fff, 32'h2000};
   logic [15:0] e_col [6] = '{16'h10, 16'h10, 16'h3, 16'h3, 16'h3, 16'h3};
   logic [7:0]  e_op [6] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h07};
   logic [2:0]  e_cause [6] = '{3'h2, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};

   tmc_cmd_engine dut_u (
      .mclk_in, .rstn_in, .cmd_valid_in, .cmd_packet_in, .cmd_ready_out,
      .rdptr_adv_out, .tt_wr_valid_out, .tt_wr_addr_out, .tt_wr_data_out,
      .tt_wr_attr_out, .tt_wr_ready_in, .cache_inval_out,
      .cache_inval_dev_out, .sys_error_out, .sys_error_cause_out,
      .lk_valid_in, .lk_requester_in, .lk_event_in, .lk_collection_in,
      .lk_done_out, .lk_accept_out, .lk_col_valid_out, .lk_target_out,
      .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out);
   tmc_table_model #(.STALL(3)) mem_u (
      .mclk_in, .rstn_in, .wr_valid_in(tt_wr_valid_out),
      .addr_in(tt_wr_addr_out), .data_in(tt_wr_data_out),
      .attr_in(tt_wr_attr_out), .ready_out(tt_wr_ready_in));

   ////////////////////////////////////////////////////////////////////
   task give_verdict;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task chk(input logic [63:0] g, input logic [63:0] e, input string m);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   function logic [63:0] cw(input logic v, input logic [34:0] t,
                            input logic [15:0] c);
      return {v, 12'h0, t, c};
   endfunction
   function logic [63:0] dw(input logic v, input logic [43:0] a);
      return {v, 11'h0, a, 8'h00};
   endfunction
   task cmd(input logic [7:0] op, input logic [31:0] dev,
            input logic [63:0] w1, input logic [63:0] w2);
      int n;
      // offer only when idle, so the packet is taken at the next edge
      while (cmd_ready_out !== 1'b1) @(negedge mclk_in);
      @(posedge mclk_in);
      cmd_valid_in  <= 1'b1;
      cmd_packet_in <= {64'h0, w2, w1, dev, 24'h0, op};
      @(posedge mclk_in);
      cmd_valid_in <= 1'b0;
      got_err = 1'b0;
      got_inv = 1'b0;
      for (n = 0; n < 40; n++) begin
         @(negedge mclk_in);
         if (sys_error_out === 1'b1) got_err = 1'b1;
         if (cache_inval_out === 1'b1) begin
            got_inv = 1'b1;
            inv_dev = cache_inval_dev_out;
         end
         if (rdptr_adv_out === 1'b1) break;
      end
      chk(rdptr_adv_out, 1'b1, "pointer advance");
      ncmd++;
   endtask
   task lk(input logic [31:0] d, input logic [31:0] e, input logic [15:0] c);
      @(posedge mclk_in);
      lk_valid_in      <= 1'b1;
      lk_requester_in  <= d;
      lk_event_in      <= e;
      lk_collection_in <= c;
      @(posedge mclk_in);
      lk_valid_in <= 1'b0;
      @(negedge mclk_in);
      chk(lk_done_out, 1'b1, "lookup done");
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e, input string m);
      @(posedge mclk_in);
      reg_rd_in   <= 1'b1;
      reg_addr_in <= a;
      @(posedge mclk_in);
      reg_rd_in <= 1'b0;
      @(negedge mclk_in);
      chk(reg_rdata_out, e, m);
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      mclk_in = 1'b0;
      forever #50 mclk_in = ~mclk_in;
   end
   // generous ceiling: the whole run needs well under a thousand cycles
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         $display("[ERR] %0t run did not finish", $time);
         give_verdict;
      end
   end

   initial begin
      {rstn_in, cmd_valid_in, lk_valid_in, reg_wr_in, reg_rd_in} = 5'h0;
      cmd_packet_in = '0;
      {lk_requester_in, lk_event_in, lk_collection_in} = '0;
      {reg_addr_in, reg_wdata_in} = '0;
      repeat (6) @(posedge mclk_in);
      rstn_in <= 1'b1;
      rd(tmc_pkg::REG_CTRL, 32'h0000_00f3, "ctrl reset");
      rd(4'h9, 32'h0, "unmapped reg");
      cmd(8'h01, 32'h0, 64'h0, cw(1'b1, 35'h7_dead_beef, 16'h3));
      lk(32'h0, 32'h0, 16'h3);
      chk(lk_col_valid_out, 1'b1, "col valid");
      chk(lk_target_out, 35'h0_dead_beef, "physical target");
      wr(tmc_pkg::REG_CTRL, 32'h0000_a0f1);
      cmd(8'h01, 32'h0, 64'h0, cw(1'b1, 35'h7_dead_beef, 16'h4));
      lk(32'h0, 32'h0, 16'h4);
      chk(lk_target_out, 35'h7_dead_beef, "full target");
      cmd(8'h01, 32'h0, 64'h0, cw(1'b0, 35'h0, 16'h3));
      lk(32'h0, 32'h0, 16'h3);
      chk(lk_col_valid_out, 1'b0, "col unmapped");
      cmd(8'h01, 32'h0, 64'h0, cw(1'b1, 35'h1, 16'h10));
      chk(got_err, 1'b1, "col range");
      chk(sys_error_cause_out, 3'h1, "col cause");
      rd(tmc_pkg::REG_STATUS, 32'h0000_0011, "status");
      $display("test collections done");
      cmd(8'h02, 32'h2, 64'hf, dw(1'b1, BASE));
      chk(got_inv, 1'b0, "first bind");
      lk(32'h2, 32'h0000_ffff, 16'h4);
      chk(lk_accept_out, 1'b1, "event in size");
      lk(32'h2, 32'h0001_0000, 16'h4);
      chk(lk_accept_out, 1'b0, "event over size");
      cmd(8'h02, 32'h2, 64'hf, dw(1'b1, BASE));
      chk(got_inv, 1'b1, "rebind");
      chk(inv_dev, 4'h2, "rebind device");
      cmd(8'h02, 32'h10, 64'hf, dw(1'b1, BASE));
      chk(sys_error_cause_out, 3'h2, "device range");
      cmd(8'h02, 32'h3, 64'h10, dw(1'b1, BASE));
      chk(sys_error_cause_out, 3'h3, "size range");
      $display("test devices done");
      cmd(8'h03, 32'h2, 64'h2005, 64'h3);
      chk(mem_u.last_addr_ff, {BASE, 8'h00} + (52'h2005 << 3), "addr");
      chk(mem_u.last_data_ff, {2'b11, 16'h3, 32'h2005}, "entry");
      chk(mem_u.last_attr_ff, 4'ha, "attributes");
      for (i = 0; i < 6; i++) begin
         cmd(e_op[i], e_dev[i], {32'h0, e_ev[i]}, {48'h0, e_col[i]});
         chk(got_err, 1'b1, "error pulse");
         chk(sys_error_cause_out, e_cause[i], "cause");
      end
      chk(mem_u.count_ff, 8'h1, "stray write");
      $display("test identity done");
      cmd(8'h02, 32'h2, 64'h1f, dw(1'b0, 44'h0));
      chk(got_err, 1'b0, "unbind size");
      lk(32'h2, 32'h2005, 16'h3);
      chk(lk_accept_out, 1'b0, "unmapped device");
      wr(tmc_pkg::REG_CTRL, 32'h0000_a0f0);
      cmd(8'h01, 32'h0, 64'h0, cw(1'b1, 35'h1, 16'h10));
      chk(got_err, 1'b0, "no support");
      rd(tmc_pkg::REG_RDPTR, 32'(ncmd * 32), "pointer");
      $display("test unmap done");
      give_verdict;
   end
endmodule
